// File: sync_serial_port.sv
// Purpose: synchronous serial port, SPI master or slave, I2C slave, I2C master start with collision check
// Assumes: pclk 20 MHz; link pins come through ssp_link; registers over APB
// Notes: one cycle of wait state on every APB access
// Operation
// R1 - software enables, reconfigures only while disabled
// R2 - pin functions follow their direction bits
// R3 - only the master drives the serial clock
// R4 - shift out one edge, capture the other
// R5 - full byte goes to buffer, flag set
// R6 - unread buffer plus new byte sets overflow
// R7 - shifter reached only through buffer register
// R8 - I2C pins are inputs unless transmitting
// R9 - acknowledge matched address or data, load buffer
// R10 - no acknowledge when full or overflowed before
// R11 - full buffer keeps old byte, flags set
// R12 - buffer read clears full, write clears overflow
// R13 - after start, eight bits on rising clock
// R14 - compare address on eighth falling edge
// R15 - match: load, full, acknowledge, flag on ninth
// R16 - ten-bit header pattern, write direction
// R17 - ten-bit byte sets update, holds clock
// R18 - after repeated start only header matched
// R19 - start with a low line aborts, collision
// R20 - data high: count from address low bits
// R21 - data seen low: assert data early
// R22 - second count, then pull clock low
// R23 - software clears the port flag itself
//
// The APB interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "ssp_regs.svh"
module sync_serial_port #(
  parameter logic [7:0] SPI_HALF = 8'(`SCK_HALF_CYC)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  ssp_link.device lnk
);
  ssp_pkg::dev_s q, d;
  ssp_pkg::mode_e mode;
  ssp_pkg::dev_ph_e nph;
  logic wr, rd, en, pol, clk_s, dat_s, sel_s, clk_r, clk_f, start, stop, done, acc, setua, spim, i2cs;

  always_comb begin
    d = q;
    wr = psel & penable & q.pready & pwrite;
    rd = psel & penable & q.pready & ~pwrite;
    d.s0 = {lnk.ptr_sel_n, lnk.dat_w, lnk.clk_w};
    d.s1 = q.s0;
    d.s2 = q.s1;
    mode = ssp_pkg::mode_e'(q.ctrl[2:0]);
    en = q.ctrl[`CTL_EN];
    pol = q.ctrl[`CTL_POL];
    spim = mode == ssp_pkg::MODE_SPI_MASTER;
    i2cs = (mode == ssp_pkg::MODE_I2C7) | (mode == ssp_pkg::MODE_I2C10);
    clk_s = q.s1[0];
    dat_s = q.s1[1];
    sel_s = ~q.s1[2] | ~q.dira[`DIRA_SEL]; // see R2
    clk_r = clk_s & ~q.s2[0];
    clk_f = ~clk_s & q.s2[0];
    start = clk_s & q.s2[1] & ~dat_s;
    stop = clk_s & ~q.s2[1] & dat_s;
    done = 1'b0;
    acc = 1'b0;
    setua = 1'b0;
    nph = q.ph;
    // apb: data prepared in the wait cycle so it leaves a flip-flop
    d.pready = psel & penable & ~q.pready;
    d.pslverr = 1'b0;
    d.prdata = 32'h0;
    if (psel & penable & ~q.pready) begin
      case (paddr)
        `SSP_IRQF: d.prdata = {24'h0, q.irqf};
        `SSP_IRQE: d.prdata = {24'h0, q.irqe};
        `SSP_CTRL: d.prdata = {24'h0, q.ctrl};
        `SSP_STAT: d.prdata = {27'h0, q.pflag, q.sflag, q.rw, q.upd, q.full};
        `SSP_BUF: d.prdata = {24'h0, q.bufr};
        `SSP_ADDR: d.prdata = {24'h0, q.addr};
        `SSP_DIRC: d.prdata = {24'h0, q.dirc};
        `SSP_DIRA: d.prdata = {24'h0, q.dira};
        `SSP_STRT: d.prdata = {30'h0, q.bcol, 1'b0};
        default: d.pslverr = 1'b1;
      endcase
    end
    if (wr) begin
      case (paddr)
        `SSP_IRQF: d.irqf = pwdata[7:0]; // see R23
        `SSP_IRQE: d.irqe = pwdata[7:0];
        `SSP_CTRL: d.ctrl = pwdata[7:0]; // see R12
        `SSP_DIRC: d.dirc = pwdata[7:0];
        `SSP_DIRA: d.dira = pwdata[7:0];
        `SSP_ADDR: begin
          d.addr = pwdata[7:0];
          d.upd = 1'b0; // see R17
          if (q.upd) begin
            d.stretch = 1'b0;
          end
        end
        `SSP_BUF: begin
          d.sr = pwdata[7:0]; // see R7
          if (spim & en & ~q.busy) begin
            d.busy = 1'b1;
            d.cnt = 4'h0;
            d.div = 8'h00;
          end
          if ((q.ph == ssp_pkg::PH_TX) & q.stretch) begin
            d.stretch = 1'b0;
            d.drv = ~pwdata[7];
          end
        end
        `SSP_STRT: begin
          d.bcol = q.bcol & pwdata[`STRT_BCOL];
          if (pwdata[`STRT_GO] & en & (mode == ssp_pkg::MODE_I2C_MASTER) & (q.ph == ssp_pkg::PH_IDLE)) begin
            if (~dat_s | ~clk_s) begin
              d.bcol = 1'b1; // see R19
            end else begin
              d.ph = ssp_pkg::PH_MST1;
              d.bct = q.addr[6:0]; // see R20
            end
          end
        end
        default: d.ctrl = q.ctrl;
      endcase
    end
    if (rd & (paddr == `SSP_BUF)) begin
      d.full = 1'b0; // see R12
    end
    // spi master makes the clock, slave follows it (see R3)
    if (en & spim & q.busy) begin
      if (q.div == SPI_HALF - 8'h01) begin
        d.div = 8'h00;
        d.sclk = ~q.sclk;
        d.cnt = q.cnt + 4'h1;
        if (q.sclk == pol) begin
          d.smp = dat_s; // see R4
        end else begin
          d.sr = {q.sr[6:0], q.smp}; // see R4
          done = q.cnt == 4'hF;
          d.busy = ~done;
        end
      end else begin
        d.div = q.div + 8'h01;
      end
    end
    if (en & (mode == ssp_pkg::MODE_SPI_SLAVE) & q.dirc[`DIR_CLK]) begin
      if (~sel_s) begin
        d.cnt = 4'h0;
      end else if (clk_s ^ q.s2[0]) begin
        d.cnt = q.cnt + 4'h1;
        if (clk_s != pol) begin
          d.smp = dat_s;
        end else begin
          d.sr = {q.sr[6:0], q.smp};
          done = q.cnt == 4'hF;
        end
      end
    end
    if (done) begin
      if (q.full) begin
        d.ctrl[`CTL_OV] = 1'b1; // see R6
      end else begin
        d.bufr = d.sr; // see R5
        d.full = 1'b1;
      end
      d.irqf[`PIR_IRQ] = 1'b1;
    end
    // i2c slave
    if (en & i2cs) begin
      if (start) begin
        d.ph = ssp_pkg::PH_ADDR1; // see R13
        d.cnt = 4'h0;
        d.nine = 1'b0;
        d.drv = 1'b0;
        d.stretch = 1'b0;
        d.sflag = 1'b1;
        d.pflag = 1'b0;
      end else if (stop) begin
        d.ph = ssp_pkg::PH_IDLE;
        d.m10 = 1'b0;
        d.drv = 1'b0;
        d.pflag = 1'b1;
        d.sflag = 1'b0;
      end else if (q.ph != ssp_pkg::PH_IDLE) begin
        if (clk_r & (q.cnt != 4'h8)) begin
          d.sr = {q.sr[6:0], dat_s}; // see R13
          d.cnt = q.cnt + 4'h1;
        end else if (clk_r & (q.ph == ssp_pkg::PH_TX) & ~q.drv) begin
          d.nack = dat_s;
        end
        if (clk_f & (q.ph == ssp_pkg::PH_TX) & (q.cnt != 4'h0) & (q.cnt != 4'h8)) begin
          d.drv = ~q.sr[7]; // see R8
        end else if (clk_f & (q.cnt == 4'h8) & ~q.nine) begin
          d.nine = 1'b1;
          d.drv = 1'b0;
          case (q.ph)
            ssp_pkg::PH_ADDR1: begin
              if ((mode == ssp_pkg::MODE_I2C7) & (q.sr[7:1] == q.addr[7:1])) begin
                acc = 1'b1; // see R14
                nph = q.sr[0] ? ssp_pkg::PH_TX : ssp_pkg::PH_RX;
              end else if ((mode == ssp_pkg::MODE_I2C10) & (q.sr[7:3] == `TEN_HI) & (q.sr[2:1] == q.addr[2:1])) begin
                if (q.m10) begin
                  acc = 1'b1; // see R18
                  nph = q.sr[0] ? ssp_pkg::PH_TX : ssp_pkg::PH_RX;
                end else if (~q.sr[0]) begin
                  acc = 1'b1; // see R16
                  setua = 1'b1;
                  nph = ssp_pkg::PH_ADDR2;
                end
              end
              d.rw = q.sr[0];
            end
            ssp_pkg::PH_ADDR2: begin
              acc = q.sr == q.addr;
              setua = 1'b1;
              d.m10 = acc;
              nph = ssp_pkg::PH_RX;
            end
            ssp_pkg::PH_RX: acc = 1'b1;
            default: acc = 1'b0;
          endcase
          if (q.ph != ssp_pkg::PH_TX) begin
            d.ph = acc ? nph : ssp_pkg::PH_IDLE;
          end
          d.nack = 1'b0;
          if (acc) begin
            d.pend = 1'b1;
            d.upd = q.upd | setua; // see R17
            d.drv = ~q.full & ~q.ctrl[`CTL_OV]; // see R10
            if (q.full) begin
              d.ctrl[`CTL_OV] = 1'b1; // see R11
            end else begin
              d.bufr = q.sr; // see R15
              d.full = 1'b1; // see R9
            end
          end
        end else if (clk_f & q.nine) begin
          d.nine = 1'b0;
          d.cnt = 4'h0;
          d.drv = 1'b0;
          d.pend = 1'b0;
          if (q.pend) begin
            d.irqf[`PIR_IRQ] = 1'b1; // see R15
          end
          if (q.upd) begin
            d.stretch = 1'b1; // see R17
          end
          if (q.ph == ssp_pkg::PH_TX) begin
            if (q.nack) begin
              d.ph = ssp_pkg::PH_IDLE;
            end else begin
              d.stretch = 1'b1;
              d.irqf[`PIR_IRQ] = 1'b1;
            end
          end
        end
      end
    end
    // master start with collision watch
    case (q.ph)
      ssp_pkg::PH_MST1: begin
        if (~dat_s) begin
          d.drv = 1'b1; // see R21
          d.bct = q.addr[6:0];
          d.ph = ssp_pkg::PH_MST2;
        end else if (~clk_s) begin
          d.bcol = 1'b1; // see R20
          d.ph = ssp_pkg::PH_IDLE;
        end else if (q.bct == 7'h00) begin
          d.drv = 1'b1; // see R21
          d.bct = q.addr[6:0];
          d.ph = ssp_pkg::PH_MST2;
        end else begin
          d.bct = q.bct - 7'h01;
        end
      end
      ssp_pkg::PH_MST2: begin
        if (q.bct == 7'h00) begin
          d.ph = ssp_pkg::PH_MHOLD; // see R22
          d.irqf[`PIR_IRQ] = 1'b1;
        end else begin
          d.bct = q.bct - 7'h01;
        end
      end
      default: d.bct = q.bct;
    endcase
    // disabled port lets go of everything, so reconfiguring is safe (see R1)
    if (~d.ctrl[`CTL_EN]) begin
      d.ph = ssp_pkg::PH_IDLE;
      d.drv = 1'b0;
      d.stretch = 1'b0;
      d.busy = 1'b0;
      d.nine = 1'b0;
      d.m10 = 1'b0;
      d.sclk = d.ctrl[`CTL_POL];
    end
    // pins (see R2)
    d.clk_oe = d.ctrl[`CTL_EN] & (spim ? ~d.dirc[`DIR_CLK] : (d.stretch | (d.ph == ssp_pkg::PH_MHOLD)));
    d.clk_o = spim & d.sclk;
    d.dat_oe = d.drv; // see R8
    d.sdo_oe = d.ctrl[`CTL_EN] & ~d.ctrl[2] & ~d.ctrl[1] & ~d.dirc[`DIR_DOUT];
    d.sdo_o = d.sr[7];
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.s0 <= 3'h7;
      q.s1 <= 3'h7;
      q.s2 <= 3'h7;
      q.dirc <= `DIR_RST;
      q.dira <= `DIR_RST;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign lnk.dev_clk_o = q.clk_o;
  assign lnk.dev_clk_oe = q.clk_oe;
  assign lnk.dev_dat_oe = q.dat_oe;
  assign lnk.dev_sdo_o = q.sdo_o;
  assign lnk.dev_sdo_oe = q.sdo_oe;
endmodule : sync_serial_port

// File: ssp_regs.svh
// Purpose: register offsets, field positions, reset values and timing counts for the serial port pair
// Assumes: 20 MHz pclk, 8-bit APB address, 32-bit APB data
// Notes: included by both ends and the bench
`ifndef SSP_REGS_SVH
`define SSP_REGS_SVH
// device end register offsets
`define SSP_IRQF 8'h0C
`define SSP_IRQE 8'h8C
`define SSP_CTRL 8'h10
`define SSP_STAT 8'h90
`define SSP_BUF 8'h14
`define SSP_ADDR 8'h94
`define SSP_DIRC 8'h18
`define SSP_DIRA 8'h98
`define SSP_STRT 8'h1C
// far end register offsets
`define PTR_CMD 8'h00
`define PTR_TX 8'h04
`define PTR_RX 8'h08
`define PTR_STAT 8'h0C
// field positions
`define CTL_OV 6
`define CTL_EN 5
`define CTL_POL 4
`define PIR_IRQ 3
`define DIR_CLK 3
`define DIR_DOUT 5
`define DIRA_SEL 5
`define STRT_GO 0
`define STRT_BCOL 1
`define CMD_GO 0
`define CMD_I2C 1
`define CMD_POL 2
`define CMD_STOP 3
// reset values
`define REG_RST 8'h00
`define DIR_RST 8'hFF
// ten-bit address header
`define TEN_HI 5'h1E
// timing
`define PCLK_NS 50
`define SCK_HALF_NS 500
`define SCK_HALF_CYC ((`SCK_HALF_NS + `PCLK_NS - 1) / `PCLK_NS)
`endif

// File: ssp_pkg.sv
// Purpose: types shared by the serial port ends
// Assumes: nothing beyond ssp_regs.svh
// Notes: states of both ends live here as packed structs
package ssp_pkg;
  typedef enum logic [2:0] {
    MODE_SPI_MASTER = 3'b000,
    MODE_SPI_SLAVE = 3'b001,
    MODE_I2C7 = 3'b010,
    MODE_I2C10 = 3'b011,
    MODE_I2C_MASTER = 3'b100
  } mode_e;
  typedef enum logic [2:0] {
    PH_IDLE = 3'b000,
    PH_ADDR1 = 3'b001,
    PH_ADDR2 = 3'b010,
    PH_RX = 3'b011,
    PH_TX = 3'b100,
    PH_MST1 = 3'b101,
    PH_MST2 = 3'b110,
    PH_MHOLD = 3'b111
  } dev_ph_e;
  typedef enum logic [2:0] {
    P_IDLE = 3'b000,
    P_SPI = 3'b001,
    P_START = 3'b010,
    P_BIT = 3'b011,
    P_STOP = 3'b100
  } ptr_st_e;
  typedef struct packed {
    logic [2:0] s0, s1, s2;
    logic [7:0] ctrl, irqf, irqe, bufr, addr, dirc, dira, sr;
    logic full, upd, rw, sflag, pflag, bcol, m10, nine, pend, nack, stretch, busy, smp, sclk, drv;
    logic [3:0] cnt;
    logic [7:0] div;
    logic [6:0] bct;
    dev_ph_e ph;
    logic clk_o, clk_oe, dat_oe, sdo_o, sdo_oe, pready, pslverr;
    logic [31:0] prdata;
  } dev_s;
  typedef struct packed {
    logic [2:0] s0, s1;
    logic i2c, pol, stop, busy, ack_n, smp;
    logic [7:0] tx, rx, sr, tm;
    logic [3:0] cnt;
    logic [1:0] step;
    ptr_st_e st;
    logic clk_o, clk_oe, dat_o, dat_oe, sel_n, pready, pslverr;
    logic [31:0] prdata;
  } ptr_s;
endpackage : ssp_pkg

// File: ssp_link.sv
// Purpose: pins between the port and its far end
// Assumes: clock and data lines pulled high when nobody pulls them low
// Notes: both drivers are and-ed, which covers open drain and lone push-pull
`timescale 1ns/1ps
interface ssp_link;
  logic dev_clk_o, dev_clk_oe, dev_dat_oe, dev_sdo_o, dev_sdo_oe;
  logic ptr_clk_o, ptr_clk_oe, ptr_dat_o, ptr_dat_oe, ptr_sel_n;
  logic clk_w, dat_w, sdo_w;
  // device only ever pulls data low
  assign clk_w = (~dev_clk_oe | dev_clk_o) & (~ptr_clk_oe | ptr_clk_o);
  assign dat_w = ~dev_dat_oe & (~ptr_dat_oe | ptr_dat_o);
  assign sdo_w = dev_sdo_oe ? dev_sdo_o : 1'b1;
  modport device (input clk_w, dat_w, ptr_sel_n, output dev_clk_o, dev_clk_oe, dev_dat_oe, dev_sdo_o, dev_sdo_oe);
  modport partner (input clk_w, dat_w, sdo_w, output ptr_clk_o, ptr_clk_oe, ptr_dat_o, ptr_dat_oe, ptr_sel_n);
endinterface : ssp_link

// File: ssp_partner.sv
// Purpose: far end, an SPI master or a byte-level I2C master driven from APB
// Assumes: device end on the same link; pclk 20 MHz
// Notes: I2C bytes read back what the line held, so tx 8'hFF reads from a transmitting slave
`timescale 1ns/1ps
`include "ssp_regs.svh"
module ssp_partner #(
  parameter logic [7:0] HALF = 8'(`SCK_HALF_CYC)
) (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // link
  ssp_link.partner lnk
);
  ssp_pkg::ptr_s q, d;
  logic acc, tick, clk_s, dat_s, sdo_s, lead;

  always_comb begin
    d = q;
    acc = psel & penable & q.pready;
    d.s0 = {lnk.sdo_w, lnk.dat_w, lnk.clk_w};
    d.s1 = q.s0;
    clk_s = q.s1[0];
    dat_s = q.s1[1];
    sdo_s = q.s1[2];
    tick = q.tm == HALF - 8'h01;
    d.tm = tick ? 8'h00 : q.tm + 8'h01;
    lead = q.clk_o == q.pol;
    d.pready = psel & penable & ~q.pready;
    d.pslverr = 1'b0;
    d.prdata = 32'h0;
    if (psel & penable & ~q.pready) begin
      case (paddr)
        `PTR_CMD: d.prdata = {28'h0, q.stop, q.pol, q.i2c, 1'b0};
        `PTR_TX: d.prdata = {24'h0, q.tx};
        `PTR_RX: d.prdata = {24'h0, q.rx};
        `PTR_STAT: d.prdata = {30'h0, q.ack_n, q.busy};
        default: d.pslverr = 1'b1;
      endcase
    end
    if (acc & pwrite & (paddr == `PTR_TX)) begin
      d.tx = pwdata[7:0];
    end
    case (q.st)
      ssp_pkg::P_IDLE: begin
        if (acc & pwrite & (paddr == `PTR_CMD) & ~q.busy) begin
          d.i2c = pwdata[`CMD_I2C];
          d.pol = pwdata[`CMD_POL];
          d.stop = pwdata[`CMD_STOP];
          if (pwdata[`CMD_GO]) begin
            d.busy = 1'b1;
            d.sr = q.tx;
            d.cnt = 4'h0;
            d.step = 2'b00;
            d.tm = 8'h00;
            if (pwdata[`CMD_I2C] & q.i2c & q.clk_oe & ~q.clk_o) begin
              // clock still held after a byte without stop: no new start
              d.st = ssp_pkg::P_BIT;
              d.dat_oe = ~q.tx[7];
            end else if (pwdata[`CMD_I2C]) begin
              d.st = ssp_pkg::P_START;
              d.dat_oe = 1'b0;
            end else begin
              // only this end makes the shift clock (see R3)
              d.st = ssp_pkg::P_SPI;
              d.sel_n = 1'b0;
              d.clk_oe = 1'b1;
              d.clk_o = pwdata[`CMD_POL];
              d.dat_oe = 1'b1;
              d.dat_o = q.tx[7];
            end
          end
        end
      end
      ssp_pkg::P_SPI: begin
        if (tick) begin
          d.clk_o = ~q.clk_o;
          d.cnt = q.cnt + 4'h1;
          if (lead) begin
            d.smp = sdo_s; // see R4
          end else begin
            d.sr = {q.sr[6:0], q.smp}; // see R4
            d.dat_o = d.sr[7];
            if (q.cnt == 4'hF) begin
              d.rx = d.sr;
              d.busy = 1'b0;
              d.sel_n = 1'b1;
              d.dat_oe = 1'b0;
              d.st = ssp_pkg::P_IDLE;
            end
          end
        end
      end
      ssp_pkg::P_START: begin
        // a slave holding the clock low simply delays us (see R17)
        if (q.step == 2'b01 & ~clk_s) begin
          d.tm = 8'h00;
        end else if (tick) begin
          d.step = q.step + 2'b01;
          case (q.step)
            2'b00: d.clk_oe = 1'b0;
            2'b01: begin
              d.dat_oe = 1'b1;
              d.dat_o = 1'b0;
            end
            default: begin
              d.clk_oe = 1'b1;
              d.clk_o = 1'b0;
              d.st = ssp_pkg::P_BIT;
              d.step = 2'b00;
              d.dat_oe = ~q.sr[7]; // see R16
            end
          endcase
        end
      end
      ssp_pkg::P_BIT: begin
        if (q.step == 2'b01 & ~clk_s) begin
          d.tm = 8'h00; // see R17
        end else if (tick & (q.step == 2'b00)) begin
          d.clk_oe = 1'b0;
          d.step = 2'b01;
        end else if (tick) begin
          d.clk_oe = 1'b1;
          d.step = 2'b00;
          d.cnt = q.cnt + 4'h1;
          if (q.cnt == 4'h8) begin
            d.ack_n = dat_s;
            d.rx = q.sr;
            if (q.stop) begin
              d.st = ssp_pkg::P_STOP;
              d.dat_oe = 1'b1;
            end else begin
              d.st = ssp_pkg::P_IDLE;
              d.busy = 1'b0;
              d.dat_oe = 1'b0;
            end
          end else begin
            d.sr = {q.sr[6:0], dat_s};
            d.dat_oe = (q.cnt != 4'h7) & ~d.sr[7];
          end
        end
      end
      ssp_pkg::P_STOP: begin
        if (q.step == 2'b01 & ~clk_s) begin
          d.tm = 8'h00;
        end else if (tick & (q.step == 2'b00)) begin
          d.clk_oe = 1'b0;
          d.step = 2'b01;
        end else if (tick) begin
          d.dat_oe = 1'b0;
          d.busy = 1'b0;
          d.st = ssp_pkg::P_IDLE;
        end
      end
      default: d.st = ssp_pkg::P_IDLE;
    endcase
    if (q.i2c | (q.st != ssp_pkg::P_SPI)) begin
      d.dat_o = d.i2c ? 1'b0 : d.dat_o;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.s0 <= 3'h7;
      q.s1 <= 3'h7;
      q.sel_n <= 1'b1;
      q.ack_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  assign prdata = q.prdata;
  assign pready = q.pready;
  assign pslverr = q.pslverr;
  assign lnk.ptr_clk_o = q.clk_o;
  assign lnk.ptr_clk_oe = q.clk_oe;
  assign lnk.ptr_dat_o = q.dat_o;
  assign lnk.ptr_dat_oe = q.dat_oe;
  assign lnk.ptr_sel_n = q.sel_n;
endmodule : ssp_partner

// File: ssp_chk.sv
// Purpose: link checks for the serial port pair
// Assumes: one pclk domain, presetn async active low
// Notes: only wires are seen, so roles are inferred from select and drives
`timescale 1ns/1ps
module ssp_chk (
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // link
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe,
  input wire logic dev_dat_oe,
  input wire logic dev_sdo_o,
  input wire logic dev_sdo_oe,
  input wire logic ptr_sel_n,
  input wire logic clk_w
);
  default clocking dc @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  chk_slave_noclk: assert property (!ptr_sel_n |-> !dev_clk_oe)
    else $error("clock driven in frame");
  chk_sdo_driven: assert property (!ptr_sel_n |-> dev_sdo_oe)
    else $error("data out idle in frame");
  chk_sdo_settle: assert property (!ptr_sel_n && $changed(clk_w) |=> $stable(dev_sdo_o) [*2])
    else $error("data out moved at edge");
  chk_dat_quiet: assert property (!ptr_sel_n |-> !dev_dat_oe)
    else $error("data pulled in frame");
  chk_ack_width: assert property ($rose(dev_dat_oe) |=> dev_dat_oe [*8])
    else $error("data pull too short");
  chk_clk_pull_low: assert property (dev_clk_oe && dev_dat_oe |-> !dev_clk_o)
    else $error("clock driven high");
  chk_start_order: assert property ($rose(dev_clk_oe) && dev_dat_oe |-> $past(dev_dat_oe) && $past(clk_w))
    else $error("clock pulled before data");
  chk_ack_release: assert property ($fell(dev_dat_oe) && !$past(dev_clk_oe) |-> !clk_w)
    else $error("data freed with clock high");
  // spi frame, slave ack, master start
  cover property ($fell(ptr_sel_n));
  cover property ($rose(dev_dat_oe) && !clk_w);
  cover property ($rose(dev_clk_oe) && dev_dat_oe);
endmodule : ssp_chk

// File: sync_serial_port_spi_i2c_test.sv
// Purpose: bench for the serial port and its far end on one link
// Assumes: one apb master serves both ends, chosen by psel_d or psel_p
// Notes: reads queue their expectation; a monitor pops one per answer
`timescale 1ns/1ps
`include "ssp_regs.svh"
module sync_serial_port_spi_i2c_test;
  localparam logic dv = 1'b0;
  localparam logic pt = 1'b1;
  logic pclk, presetn, psel_d, psel_p, penable, pwrite, want;
  logic pready_d, pready_p, pslverr_d, pslverr_p;
  logic [7:0] paddr, b0, b1;
  logic [31:0] pwdata, prdata_d, prdata_p, rdv, r;
  logic [16:0] q[$];
  logic [16:0] e;
  int bad_count, comparisons, n;
  integer seed;
  ssp_link lnk();
  sync_serial_port i_sync_serial_port (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel_d),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_d), .pready(pready_d),
    .pslverr(pslverr_d), .lnk(lnk.device));
  ssp_partner i_ssp_partner (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel_p),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata_p), .pready(pready_p),
    .pslverr(pslverr_p), .lnk(lnk.partner));
  ssp_chk i_ssp_chk (.pclk(pclk), .presetn(presetn), .dev_clk_o(lnk.dev_clk_o), .dev_clk_oe(lnk.dev_clk_oe),
    .dev_dat_oe(lnk.dev_dat_oe), .dev_sdo_o(lnk.dev_sdo_o), .dev_sdo_oe(lnk.dev_sdo_oe),
    .ptr_sel_n(lnk.ptr_sel_n), .clk_w(lnk.clk_w));
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : report_and_stop
  task automatic hang;
    bad_count++;
    $display("mismatch at %0t: no answer", $time);
    report_and_stop();
  endtask : hang
  task automatic chk(input logic [32:0] seen, input logic [32:0] exp);
    comparisons++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // one apb transfer, held until pready is seen high
  task automatic xf(input logic p, input logic [7:0] a, input logic w, input logic [7:0] d);
    psel_d <= !p;
    psel_p <= p;
    paddr <= a;
    pwrite <= w;
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while ((p ? pready_p : pready_d) !== 1'b1 && n < 20);
    rdv = p ? prdata_p : prdata_d;
    psel_d <= 1'b0;
    psel_p <= 1'b0;
    penable <= 1'b0;
    if (n >= 20)
      hang();
    @(posedge pclk);
  endtask : xf
  task automatic wr(input logic p, input logic [7:0] a, input logic [7:0] d);
    xf(p, a, 1'b1, d);
  endtask : wr
  // upper bits read zero
  task automatic rd(input logic p, input logic [7:0] a, input logic [7:0] m, input logic [7:0] x,
    input logic er = 1'b0);
    q.push_back({er, m, x});
    want = 1'b1;
    xf(p, a, 1'b0, 8'h00);
    want = 1'b0;
  endtask : rd
  task automatic poll(input logic p, input logic [7:0] a, input logic [7:0] m, input logic [7:0] x);
    for (int k = 0; k < 500; k++) begin
      xf(p, a, 1'b0, 8'h00);
      if ((rdv[7:0] & m) === x)
        return;
    end
    hang();
  endtask : poll
  // far end sends one byte and finishes
  task automatic go(input logic [7:0] d, input logic [7:0] c);
    wr(pt, `PTR_TX, d);
    wr(pt, `PTR_CMD, c);
    poll(pt, `PTR_STAT, 8'h01, 8'h00);
  endtask : go
  always @(posedge pclk) begin
    if (want && penable && !pwrite && (psel_d && pready_d === 1'b1 || psel_p && pready_p === 1'b1)) begin
      e = q.pop_front();
      r = psel_p ? prdata_p : prdata_d;
      chk({psel_p ? pslverr_p : pslverr_d, r[31:8], r[7:0] & e[15:8]}, {e[16], 24'h0, e[7:0]});
    end
  end
  initial begin
    seed = 32'h2fc6f447;
    presetn = 1'b0;
    psel_d = 1'b0;
    psel_p = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    want = 1'b0;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    repeat (4) @(posedge pclk);
    rd(dv, `SSP_IRQF, 8'hFF, 8'h00);
    rd(dv, `SSP_IRQE, 8'hFF, 8'h00);
    rd(dv, `SSP_DIRC, 8'hFF, 8'hFF);
    wr(dv, `SSP_IRQE, 8'hFF);
    rd(dv, `SSP_IRQE, 8'hFF, 8'hFF);
    rd(dv, 8'hFC, 8'h00, 8'h00, 1'b1);
    $display("registers done");
    // spi slave, set up while off, select ignored, clock idles high
    wr(dv, `SSP_CTRL, 8'h11);
    wr(dv, `SSP_DIRC, 8'hDF);
    wr(dv, `SSP_DIRA, 8'h00);
    wr(dv, `SSP_CTRL, 8'h31);
    b0 = 8'($random(seed));
    b1 = 8'($random(seed));
    wr(dv, `SSP_BUF, b0);
    go(b1, 8'h05);
    rd(pt, `PTR_RX, 8'hFF, b0);
    rd(dv, `SSP_IRQF, 8'h08, 8'h08);
    rd(dv, `SSP_STAT, 8'h01, 8'h01);
    go(8'h5A, 8'h05);
    rd(dv, `SSP_CTRL, 8'h40, 8'h40);
    rd(dv, `SSP_BUF, 8'hFF, b1);
    rd(dv, `SSP_STAT, 8'h01, 8'h00);
    wr(dv, `SSP_CTRL, 8'h31);
    wr(dv, `SSP_IRQF, 8'h00);
    rd(dv, `SSP_CTRL, 8'h40, 8'h00);
    rd(dv, `SSP_IRQF, 8'h08, 8'h00);
    $display("spi done");
    // i2c slave: address, one acked byte, one byte into a full buffer
    wr(dv, `SSP_CTRL, 8'h02);
    wr(dv, `SSP_ADDR, 8'hA6);
    wr(dv, `SSP_CTRL, 8'h22);
    go(8'hA6, 8'h03);
    rd(pt, `PTR_STAT, 8'h02, 8'h00);
    rd(dv, `SSP_IRQF, 8'h08, 8'h08);
    rd(dv, `SSP_BUF, 8'hFF, 8'hA6);
    wr(dv, `SSP_IRQF, 8'h00);
    go(b0, 8'h03);
    rd(pt, `PTR_STAT, 8'h02, 8'h00);
    wr(dv, `SSP_IRQF, 8'h00);
    go(b1, 8'h0B);
    rd(pt, `PTR_STAT, 8'h02, 8'h02);
    rd(dv, `SSP_CTRL, 8'h40, 8'h40);
    rd(dv, `SSP_BUF, 8'hFF, b0);
    rd(dv, `SSP_IRQF, 8'h08, 8'h08);
    $display("i2c done");
    // ten-bit address, clock held after each address byte
    wr(dv, `SSP_CTRL, 8'h03);
    wr(dv, `SSP_ADDR, 8'hF2);
    wr(dv, `SSP_CTRL, 8'h23);
    go(8'hF2, 8'h03);
    rd(dv, `SSP_STAT, 8'h03, 8'h03);
    rd(dv, `SSP_BUF, 8'hFF, 8'hF2);
    wr(dv, `SSP_ADDR, 8'h5C);
    wr(pt, `PTR_TX, 8'h5C);
    wr(pt, `PTR_CMD, 8'h0B);
    poll(dv, `SSP_STAT, 8'h02, 8'h02);
    wr(dv, `SSP_ADDR, 8'hF2);
    poll(pt, `PTR_STAT, 8'h01, 8'h00);
    rd(pt, `PTR_STAT, 8'h02, 8'h00);
    $display("ten-bit done");
    // master start on a free bus, then on a bus already held low
    wr(dv, `SSP_CTRL, 8'h04);
    wr(dv, `SSP_ADDR, 8'h03);
    wr(dv, `SSP_IRQF, 8'h00);
    wr(dv, `SSP_CTRL, 8'h24);
    wr(dv, `SSP_STRT, 8'h01);
    poll(dv, `SSP_IRQF, 8'h08, 8'h08);
    rd(dv, `SSP_STRT, 8'h02, 8'h00);
    wr(dv, `SSP_CTRL, 8'h04);
    wr(dv, `SSP_CTRL, 8'h24);
    wr(pt, `PTR_TX, 8'h00);
    wr(pt, `PTR_CMD, 8'h03);
    // far end start pulls data low about twenty cycles in
    repeat (22) @(posedge pclk);
    wr(dv, `SSP_STRT, 8'h01);
    rd(dv, `SSP_STRT, 8'h02, 8'h02);
    poll(pt, `PTR_STAT, 8'h01, 8'h00);
    $display("start done");
    report_and_stop();
  end
endmodule : sync_serial_port_spi_i2c_test
